// >>> verilog/sar_defs.vh
// timing, framing and state constants shared by the converter readout design
`ifndef SAR_DEFS_VH
`define SAR_DEFS_VH

// clock period of the block
`define SAR_CLK_PERIOD_NS 100
// longest conversion time with the gain stage bypassed and in use
`define SAR_TCONV_BYP_NS 660
`define SAR_TCONV_PGA_NS 1550
// longest times round down to whole cycles, never below one
`define SAR_CONV_BYP_CYC ((`SAR_TCONV_BYP_NS / `SAR_CLK_PERIOD_NS) < 1 ? 1 : \
    (`SAR_TCONV_BYP_NS / `SAR_CLK_PERIOD_NS))
`define SAR_CONV_PGA_CYC ((`SAR_TCONV_PGA_NS / `SAR_CLK_PERIOD_NS) < 1 ? 1 : \
    (`SAR_TCONV_PGA_NS / `SAR_CLK_PERIOD_NS))
// least chip select high time asked of the host, normal and low power
`define SAR_TCSH_NORM_NS 150
`define SAR_TCSH_LP_NS 500

// serial frame: result bits, then channel bits, then gain bits
`define SAR_DATA_BITS 14
`define SAR_SEL_BITS 3
`define SAR_FRAME_BITS 20

// reset values of the pin-facing outputs
`define SAR_SDO_OE_N_RST 1'b1
`define SAR_BUSY_RST 1'b0

// sequencer states
`define SAR_ST_IDLE 2'h0
`define SAR_ST_CONV 2'h1
`define SAR_ST_READ 2'h2

`endif

// >>> verilog/sar_fifo.v
// synchronous valid/ready fifo holding digitised samples from the converter core
`timescale 1ns/1ps
module sar_fifo #(
    parameter WIDTH = 14,
    parameter DEPTH = 16,
    parameter AW = 4
) (
    // clock and reset
    input wire clk,
    input wire reset,
    // filling side
    input wire [WIDTH-1:0] in_data,
    input wire in_valid,
    output wire in_ready,
    // draining side
    output wire [WIDTH-1:0] out_data,
    output wire out_valid,
    input wire out_ready
);

reg [WIDTH-1:0] mem [0:DEPTH-1];
reg [AW:0] wr_ptr;
reg [AW:0] rd_ptr;
wire do_write;
wire do_read;

// one extra pointer bit tells full from empty
assign out_valid = (wr_ptr != rd_ptr);
assign in_ready = (wr_ptr[AW-1:0] != rd_ptr[AW-1:0]) || (wr_ptr[AW] == rd_ptr[AW]);
assign do_write = in_valid & in_ready;
assign do_read = out_valid & out_ready;
assign out_data = mem[rd_ptr[AW-1:0]];

// storage has no reset, only the pointers do
always @(posedge clk) begin
    if (do_write) begin
        mem[wr_ptr[AW-1:0]] <= in_data;
    end
end

// pointer update
always @(posedge clk) begin
    if (reset) begin
        wr_ptr <= {(AW+1){1'b0}};
        rd_ptr <= {(AW+1){1'b0}};
    end else begin
        if (do_write) begin
            wr_ptr <= wr_ptr + 1'b1;
        end
        if (do_read) begin
            rd_ptr <= rd_ptr + 1'b1;
        end
    end
end

endmodule // sar_fifo

// >>> verilog/sar_adc_readout.v
// conversion sequencer and serial readout of an eight-channel 14-bit sar converter
`timescale 1ns/1ps
`include "sar_defs.vh"
module sar_adc_readout #(
    parameter DATA_BITS = `SAR_DATA_BITS,
    parameter FIFO_DEPTH = 16,
    parameter FIFO_AW = 4
) (
    // clock and reset
    input wire clk,
    input wire reset,
    // serial pins from the host
    input wire cs_n,
    input wire sck,
    output reg sdo,
    output reg sdo_oe_n,
    output reg busy,
    // selection pins from the host
    input wire [2:0] channel_select,
    input wire [2:0] gain_select,
    input wire gain_bypass,
    input wire low_power_select,
    // controls toward the analog front end
    output reg [2:0] mux_channel,
    output reg [2:0] pga_gain,
    output reg pga_bypass,
    output reg sample_strobe,
    // digitised samples from the converter core
    input wire [DATA_BITS-1:0] core_data,
    input wire core_valid,
    output wire core_ready,
    // status
    output reg sample_missed,
    output reg result_invalid
);

reg cs_meta;
reg cs_sync;
reg cs_prev;
reg sck_meta;
reg sck_sync;
reg sck_prev;
reg [2:0] sel_ch_meta;
reg [2:0] sel_ch;
reg [2:0] sel_gain_meta;
reg [2:0] sel_gain;
reg bypass_meta;
reg bypass_sync;
reg lp_meta;
reg lp_sync;
reg [1:0] state;
reg [7:0] conv_cnt;
reg [`SAR_FRAME_BITS-1:0] frame;
reg awake;
wire cs_fall;
wire cs_rise;
wire sck_rise;
wire [DATA_BITS-1:0] head_data;
wire head_valid;

// counts are reckoned as integers, then cut to the counter width on purpose;
// the counter loads the last value so busy stands exactly the whole count
localparam integer CONV_BYP_CYC = `SAR_CONV_BYP_CYC;
localparam integer CONV_PGA_CYC = `SAR_CONV_PGA_CYC;
localparam [7:0] CONV_BYP_LAST = CONV_BYP_CYC[7:0] - 8'h01;
localparam [7:0] CONV_PGA_LAST = CONV_PGA_CYC[7:0] - 8'h01;

// edge of a synchronised level: rising when dir is high, falling when low
function edge_seen;
    input prev_level;
    input now_level;
    input dir;
    begin
        edge_seen = dir ? (~prev_level & now_level) : (prev_level & ~now_level);
    end
endfunction

// the select words cross bit by bit; they are only taken at a chip select fall,
// which passes the same two stages as they do, so a host that holds them steady is safe
// two-stage synchronisers; logic reads the second stage, and the third for cs and sck edges
always @(posedge clk) begin
    if (reset) begin
        cs_meta <= 1'b1;
        cs_sync <= 1'b1;
        cs_prev <= 1'b1;
        sck_meta <= 1'b0;
        sck_sync <= 1'b0;
        sck_prev <= 1'b0;
        sel_ch_meta <= 3'h0;
        sel_ch <= 3'h0;
        sel_gain_meta <= 3'h0;
        sel_gain <= 3'h0;
        bypass_meta <= 1'b0;
        bypass_sync <= 1'b0;
        lp_meta <= 1'b0;
        lp_sync <= 1'b0;
    end else begin
        cs_meta <= cs_n;
        cs_sync <= cs_meta;
        cs_prev <= cs_sync;
        sck_meta <= sck;
        sck_sync <= sck_meta;
        sck_prev <= sck_sync;
        sel_ch_meta <= channel_select;
        sel_ch <= sel_ch_meta;
        sel_gain_meta <= gain_select;
        sel_gain <= sel_gain_meta;
        bypass_meta <= gain_bypass;
        bypass_sync <= bypass_meta;
        lp_meta <= low_power_select;
        lp_sync <= lp_meta;
    end
end

// edges are found after synchronising, so the sck limit is set by clk, not the pin
assign cs_fall = edge_seen(cs_prev, cs_sync, 1'b0);
assign cs_rise = edge_seen(cs_prev, cs_sync, 1'b1);
assign sck_rise = edge_seen(sck_prev, sck_sync, 1'b1);

// samples wait here; the head is taken only at a chip select fall, so the fifo fills
sar_fifo #(
    .WIDTH(DATA_BITS),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
) u_fifo (
    .clk(clk),
    .reset(reset),
    .in_data(core_data),
    .in_valid(core_valid),
    .in_ready(core_ready),
    .out_data(head_data),
    .out_valid(head_valid),
    .out_ready(cs_fall)
);

// sequencer: idle with cs high, convert on internal count, then read out
always @(posedge clk) begin
    if (reset) begin
        state <= `SAR_ST_IDLE;
        conv_cnt <= 8'h00;
        frame <= {`SAR_FRAME_BITS{1'b0}};
        sdo <= 1'b0;
        sdo_oe_n <= `SAR_SDO_OE_N_RST;
        busy <= `SAR_BUSY_RST;
        mux_channel <= 3'h0;
        pga_gain <= 3'h0;
        pga_bypass <= 1'b0;
        sample_strobe <= 1'b0;
        sample_missed <= 1'b0;
        result_invalid <= 1'b0;
        awake <= 1'b0;
    end else begin
        sample_strobe <= 1'b0;
        if (cs_fall) begin
            // a fall restarts the sequence even mid-readout
            mux_channel <= sel_ch;
            pga_gain <= sel_gain;
            pga_bypass <= bypass_sync;
            sample_strobe <= 1'b1;
            // an empty fifo gives a zero result, flagged by sample_missed
            frame <= {(head_valid ? head_data : {DATA_BITS{1'b0}}),
                sel_ch, sel_gain};
            sample_missed <= ~head_valid;
            // first sample after power-up is flagged, not suppressed, when it is taken in normal mode
            result_invalid <= ~lp_sync & ~awake;
            awake <= 1'b1;
            conv_cnt <= bypass_sync ? CONV_BYP_LAST : CONV_PGA_LAST;
            state <= `SAR_ST_CONV;
            busy <= 1'b1;
            sdo <= 1'b0;
            sdo_oe_n <= 1'b0;
        end else if (cs_rise) begin
            state <= `SAR_ST_IDLE;
            busy <= 1'b0;
            sdo <= 1'b0;
            sdo_oe_n <= 1'b1;
        end else begin
            case (state)
                `SAR_ST_CONV: begin
                    // sck edges are ignored here; count runs from clk alone
                    if (conv_cnt == 8'h00) begin
                        state <= `SAR_ST_READ;
                        busy <= 1'b0;
                        sdo <= frame[`SAR_FRAME_BITS-1];
                    end else begin
                        conv_cnt <= conv_cnt - 8'h01;
                    end
                end
                `SAR_ST_READ: begin
                    if (sck_rise) begin
                        // zeros fill in, so edges past the six tag bits give low
                        frame <= {frame[`SAR_FRAME_BITS-2:0], 1'b0};
                        sdo <= frame[`SAR_FRAME_BITS-2];
                    end
                end
                `SAR_ST_IDLE: begin
                    busy <= 1'b0;
                end
                default: begin
                    state <= `SAR_ST_IDLE;
                end
            endcase
        end
    end
end

endmodule // sar_adc_readout

// >>> test/sar_adc_readout_chk.sv
// assertion checker for the converter readout block
`timescale 1ns/1ps
module sar_chk (
    // clock and reset
    input logic clk,
    input logic reset,
    // serial pins
    input logic cs_n,
    input logic sdo,
    input logic sdo_oe_n,
    input logic busy,
    // selection and front end
    input logic [2:0] channel_select,
    input logic [2:0] mux_channel,
    input logic [2:0] gain_select,
    input logic [2:0] pga_gain,
    input logic gain_bypass,
    input logic pga_bypass,
    input logic sample_strobe
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    // start of a conversion and its sampling instant
    start_strobe_a: assert property ($rose(busy) |-> sample_strobe)
        else $error("busy rose without sample strobe");
    strobe_pulse_a: assert property (sample_strobe |=> !sample_strobe)
        else $error("sample strobe longer than one cycle");
    strobe_drive_a: assert property (sample_strobe |-> busy && !sdo_oe_n)
        else $error("data out not enabled at start");
    // conversion length depends only on the gain stage, never on the serial clock
    busy_bypass_a: assert property ($rose(busy) && pga_bypass |-> busy[*6] ##1 !busy)
        else $error("bypassed conversion length wrong");
    busy_gain_a: assert property ($rose(busy) && !pga_bypass |->
        busy[*8] ##1 busy[*7] ##1 !busy)
        else $error("gain conversion length wrong");
    // data out released while deselected, held low while converting; channel and gain latched at sampling
    oe_idle_a: assert property (cs_n[*5] |-> sdo_oe_n)
        else $error("data out driven while deselected");
    busy_low_a: assert property (busy |-> !sdo)
        else $error("data out not low during conversion");
    chan_latch_a: assert property (sample_strobe |-> mux_channel == channel_select)
        else $error("channel not latched at sampling");
    gain_latch_a: assert property (sample_strobe |->
        pga_gain == gain_select && pga_bypass == gain_bypass)
        else $error("gain not latched at sampling");
endmodule // sar_chk

bind sar_adc_readout sar_chk chk (.clk, .reset, .cs_n, .sdo, .sdo_oe_n, .busy,
    .channel_select, .mux_channel, .pga_bypass, .sample_strobe,
    .gain_select, .pga_gain, .gain_bypass);

// >>> test/sar_host.sv
// host model: drives chip select and serial clock, shifts in the frame
`timescale 1ns/1ps
module sar_host (
    // clock
    input logic clk,
    // serial pins
    input logic sdo,
    input logic sdo_oe_n,
    input logic busy,
    output logic cs_n,
    output logic sck,
    // captured frame
    output logic [19:0] got,
    output logic got_v,
    // set when a busy wait ran out of cycles
    output logic late
);
    // a released line reads inverted so a stale value cannot pass
    wire line = sdo_oe_n ? ~sdo : sdo;
    logic [19:0] w;
    initial begin
        cs_n = 1'b1;
        sck = 1'b0;
        got = 20'h00000;
        got_v = 1'b0;
        late = 1'b0;
    end
    // one frame with nr serial clock rises after the msb
    task frame(input int nr);
        int i;
        w = 20'h00000;
        @(posedge clk) cs_n <= 1'b0;
        for (i = 0; i < 10 && busy !== 1'b1; i++) @(negedge clk);
        if (busy !== 1'b1) late = 1'b1;
        for (i = 0; i < 20 && busy !== 1'b0; i++) @(negedge clk);
        if (busy !== 1'b0) late = 1'b1;
        w = {w[18:0], line};
        // 800ns serial clock, far below the rate limit
        repeat (nr) begin
            @(posedge clk) sck <= 1'b1;
            repeat (4) @(posedge clk);
            sck <= 1'b0;
            repeat (4) @(negedge clk);
            w = {w[18:0], line};
        end
        @(posedge clk) cs_n <= 1'b1;
        got <= w;
        got_v <= 1'b1;
        @(posedge clk) got_v <= 1'b0;
        repeat (5) @(posedge clk);
    endtask
endmodule // sar_host

// >>> test/tb_sar_adc_readout.sv
// self-checking bench for the converter readout block
`timescale 1ns/1ps
module tb_sar_adc_readout;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic cs_n, sck, sdo, sdo_oe_n, busy, got_v, ready, missed, invalid, late;
    logic [2:0] ch = 3'h0, gn = 3'h0;
    logic byp = 1'b0, lp = 1'b0, cv = 1'b0;
    logic [13:0] cd = 14'h0000;
    logic [13:0] wq [16];
    logic [19:0] got;
    logic [19:0] exp_q [$];
    int bad_count = 0, cmp_count = 0, seed = 34, k, nr;
    always #50 clk = ~clk;
    sar_adc_readout dut (.clk, .reset, .cs_n, .sck, .sdo, .sdo_oe_n, .busy,
        .channel_select(ch), .gain_select(gn), .gain_bypass(byp), .low_power_select(lp),
        .mux_channel(), .pga_gain(), .pga_bypass(), .sample_strobe(),
        .core_data(cd), .core_valid(cv), .core_ready(ready),
        .sample_missed(missed), .result_invalid(invalid));
    sar_host host (.clk, .sdo, .sdo_oe_n, .busy, .cs_n, .sck, .got, .got_v, .late);
    task check(input logic ok, input string what);
        cmp_count++;
        if (ok !== 1'b1) begin
            bad_count++;
            $display("[FAIL] %0t %s", $time, what);
        end
    endtask
    task stop_test;
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // each captured frame against the oldest noted one
    always @(posedge clk) if (got_v === 1'b1) check(got === exp_q.pop_front(), "frame");
    // a hang counts as a mismatch
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        stop_test;
    end
    initial begin
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        // fill the fifo back to back until it refuses
        for (k = 0; k < 16; k++) begin
            wq[k] = 14'($random(seed));
            cd <= wq[k];
            cv <= 1'b1;
            @(posedge clk);
        end
        cv <= 1'b0;
        @(negedge clk) check(ready === 1'b0, "fifo full");
        @(posedge clk) cv <= 1'b1;
        @(posedge clk) cv <= 1'b0;
        // drain over every gain and channel code, mixed modes and lengths
        for (k = 0; k < 17; k++) begin
            @(posedge clk) begin
                ch <= k[2:0] ^ 3'h5;
                gn <= k[2:0];
                byp <= k[0];
                lp <= k[1];
            end
            nr = (k == 3) ? 13 : (k == 6) ? 16 : 19;
            exp_q.push_back({(k < 16) ? wq[k] : 14'h0000, k[2:0] ^ 3'h5, k[2:0]}
                >> (19 - nr));
            host.frame(nr);
            if (k < 2) check(invalid === (k == 0), "first sample flag");
            check(late === 1'b0, "busy wait ran out");
            if (k < 16) check(missed === 1'b0, "stored sample lost");
        end
        check(missed === 1'b1, "empty fifo sample");
        stop_test;
    end
endmodule // tb_sar_adc_readout
